// ==== inc/nb_rail_pkg.sv ====
package nb_rail_pkg;

  // timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int TRIG_DELAY_NS   = 20000;
  localparam int ACTION_DELAY_NS = 8000;
  localparam int SETTLE_NS       = 2000;
  // least times round up to whole cycles
  localparam int TRIG_CYCLES     = (TRIG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACTION_CYCLES   = (ACTION_DELAY_NS + SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // offset
  localparam logic [11:0] OFFSET_MIN_MV     = 12'h12c;  // 300 mV
  localparam logic [12:0] EXT_OFFSET_REF_MV = 13'h04b0; // 1200 mV

  // current monitor converter, microvolt input
  localparam logic [21:0] ADC_LSB_UV   = 22'h00186a;  // 6250 uV
  localparam logic [21:0] ADC_FULL_UV  = 22'h30bb56;  // 3193686 uV
  localparam logic [8:0]  ADC_MAX_CODE = 9'h1ff;      // 511 levels

  // downward step low-side suppression
  localparam logic [2:0] DVID_DOWN_PULSES = 3'h4;

  // setting pin field positions
  localparam int EXT_OFS_EN_BIT = 0;
  localparam int SLEW_BIT       = 2;
  localparam int RAMP_LSB       = 0;

  // completion delay per slew compensation code, cycles
  localparam logic [3:0] COMP_DLY_0 = 4'h0;
  localparam logic [3:0] COMP_DLY_1 = 4'h2;
  localparam logic [3:0] COMP_DLY_2 = 4'h4;
  localparam logic [3:0] COMP_DLY_3 = 4'h8;

  // sustained limit as percent of peak limit
  localparam logic [6:0] TDC_PCT_0 = 7'h50;
  localparam logic [6:0] TDC_PCT_1 = 7'h55;
  localparam logic [6:0] TDC_PCT_2 = 7'h5a;
  localparam logic [6:0] TDC_PCT_3 = 7'h64;

  // reset values
  localparam logic [1:0] PHASES_RST = 2'h2;

  typedef enum logic [2:0] {
    OCP_IDLE     = 3'b001,
    OCP_TRIPPED  = 3'b010,
    OCP_SHUTDOWN = 3'b100
  } ocp_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        done;
  } timer_st_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       pulse;
  } pulse_st_t;

  typedef struct packed {
    logic        en_prev;
    logic        init_ofs_en;
    logic [13:0] rail_target;
    logic [1:0]  phases;
    logic        ls_off;
    logic [2:0]  pulse_cnt;
    logic [2:0]  ramp_sel;
    logic [1:0]  slew;
    logic [3:0]  done_cnt;
    logic        done_busy;
    logic        vid_done;
    logic [8:0]  adc_code;
    logic [11:0] acc;
    logic        peak_over;
    logic [1:0]  override;
    ocp_state_t  ocp;
    logic        flag_n;
    logic        gates_off;
  } nb_state_t;

endpackage

// ==== rtl/nb_rail_control.sv ====
// Operation
// [RULE_01] offset pin below 0.3V at enable disables initial offset
// [RULE_02] target adds initial offset and enabled external offset
// [RULE_03] second setting pin enables external offset
// [RULE_04] upward voltage change forces two phases
// [RULE_05] downward voltage change keeps phase count
// [RULE_06] setting pins pick slew compensation and completion timing
// [RULE_07] light-load downward step: low side off, four pulses
// [RULE_08] diode emulation selects modified ramp, else pin amplitude
// [RULE_09] current monitor digitised to 511 levels of 6.25mV
// [RULE_10] quick response pulse overrides all active on-times
// [RULE_11] sustained trip needs averaged overcurrent for trigger delay
// [RULE_12] peak trip is immediate, no time qualification
// [RULE_13] any trip asserts flag and starts action delay
// [RULE_14] still over after delay: all switches off
// [RULE_15] sustained limit is percentage of peak limit
// [RULE_16] peak limit at monitor full scale
// [RULE_17] per-phase overcurrent turns all switches off
// [RULE_18] delays are counters restarting when condition clears
`timescale 1ns/10ps
module nb_rail_control #(
  parameter int TRIG_CYCLES   = nb_rail_pkg::TRIG_CYCLES,
  parameter int ACTION_CYCLES = nb_rail_pkg::ACTION_CYCLES
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // processor voltage interface side
  input  wire logic               enable,
  input  wire logic [11:0]        vid_target_mv,
  input  wire logic signed [11:0] initial_offset_mv,
  input  wire logic               dvid_up,
  input  wire logic               dvid_down,
  input  wire logic               dvid_settled,
  input  wire logic [1:0]         requested_phases,
  // setting pins and digitised analog levels
  input  wire logic [11:0]        offset_input_pin,
  input  wire logic [2:0]         first_setting_pin,
  input  wire logic [2:0]         second_setting_pin,
  input  wire logic [21:0]        current_monitor_pin,
  input  wire logic [1:0]         tdc_percent_sel,
  // power stage status
  input  wire logic               ccm_light_load,
  input  wire logic               diode_emulation,
  input  wire logic               pwm_pulse,
  input  wire logic               qr_trigger,
  input  wire logic [7:0]         on_time_cycles,
  input  wire logic [1:0]         per_phase_overcurrent,
  // rail control outputs
  output logic signed [13:0]      rail_target_mv,
  output logic [1:0]              phase_count,
  output logic [1:0]              slew_compensation_bits,
  output logic                    vid_change_done,
  output logic                    low_side_off,
  output logic [2:0]              ramp_select,
  output logic [8:0]              load_current_code,
  output logic [1:0]              on_time_override,
  // protection outputs
  output logic                    sustained_overcurrent_trip,
  output logic                    peak_overcurrent_trip,
  output logic                    overcurrent_flag_n,
  output logic                    gates_off
);

  nb_rail_pkg::nb_state_t s_q;
  nb_rail_pkg::nb_state_t s_d;

  logic        qr_pulse;
  logic        action_done;
  logic        sustained_over;
  logic        any_over;
  logic [21:0] adc_div;
  logic [8:0]  avg_code;
  logic [8:0]  sustained_limit;
  logic [15:0] limit_prod;

  function automatic logic [3:0] comp_delay(input logic [1:0] sel);
    case (sel)
      2'h0:    comp_delay = nb_rail_pkg::COMP_DLY_0;
      2'h1:    comp_delay = nb_rail_pkg::COMP_DLY_1;
      2'h2:    comp_delay = nb_rail_pkg::COMP_DLY_2;
      default: comp_delay = nb_rail_pkg::COMP_DLY_3;
    endcase
  endfunction

  function automatic logic [6:0] tdc_percent(input logic [1:0] sel);
    case (sel)
      2'h0:    tdc_percent = nb_rail_pkg::TDC_PCT_0;
      2'h1:    tdc_percent = nb_rail_pkg::TDC_PCT_1;
      2'h2:    tdc_percent = nb_rail_pkg::TDC_PCT_2;
      default: tdc_percent = nb_rail_pkg::TDC_PCT_3;
    endcase
  endfunction

  function automatic logic [1:0] phase_mask(input logic [1:0] n);
    if (n >= 2'h2)
      phase_mask = 2'b11;
    else if (n == 2'h1)
      phase_mask = 2'b01;
    else
      phase_mask = 2'b00;
  endfunction

  // peak limit sits at converter full scale, sustained limit a fraction of it
  assign limit_prod      = 16'(nb_rail_pkg::ADC_MAX_CODE) * 16'(tdc_percent(tdc_percent_sel)); // [RULE_15] [RULE_16]
  assign sustained_limit = 9'(limit_prod / 16'h0064);
  assign adc_div         = current_monitor_pin / nb_rail_pkg::ADC_LSB_UV;
  assign avg_code        = s_q.acc[11:3];
  assign sustained_over  = avg_code > sustained_limit;
  assign any_over        = sustained_over || s_q.peak_over;

  ocp_delay_timer #(
    .COUNT (TRIG_CYCLES)
  ) u_trigger_delay (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (sustained_over && enable),  // [RULE_11] [RULE_18]
    .done    (sustained_overcurrent_trip)
  );

  ocp_delay_timer #(
    .COUNT (ACTION_CYCLES)
  ) u_action_delay (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (s_q.ocp == nb_rail_pkg::OCP_TRIPPED && any_over), // [RULE_18]
    .done    (action_done)
  );

  quick_pulse_gen u_quick_pulse (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .trigger   (qr_trigger && enable),
    .on_cycles (on_time_cycles),
    .pulse     (qr_pulse)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.en_prev  = enable;
    s_d.vid_done = 1'b0;

    // strap-like capture of the offset pin only at the enable edge
    if (enable && !s_q.en_prev)
      s_d.init_ofs_en = offset_input_pin >= nb_rail_pkg::OFFSET_MIN_MV; // [RULE_01]

    s_d.rail_target = 14'(vid_target_mv);
    if (s_q.init_ofs_en)
      s_d.rail_target = s_d.rail_target + 14'(initial_offset_mv); // [RULE_02]
    if (second_setting_pin[nb_rail_pkg::EXT_OFS_EN_BIT])          // [RULE_03]
      s_d.rail_target = s_d.rail_target + 14'(offset_input_pin)
                        - 14'(nb_rail_pkg::EXT_OFFSET_REF_MV);    // [RULE_02]

    if (dvid_up)
      s_d.phases = 2'h2;              // [RULE_04]
    else if (dvid_down)
      s_d.phases = s_q.phases;        // [RULE_05]
    else
      s_d.phases = requested_phases;

    s_d.slew = {first_setting_pin[nb_rail_pkg::SLEW_BIT],
                second_setting_pin[nb_rail_pkg::SLEW_BIT]}; // [RULE_06]
    if (dvid_settled)
    begin
      s_d.done_busy = 1'b1;
      s_d.done_cnt  = comp_delay(s_q.slew); // [RULE_06]
    end
    else if (s_q.done_busy)
    begin
      if (s_q.done_cnt == 4'h0)
      begin
        s_d.done_busy = 1'b0;
        s_d.vid_done  = 1'b1;
      end
      else
        s_d.done_cnt = s_q.done_cnt - 4'h1;
    end

    // blocking the low side stops negative inductor current on the way down
    if (dvid_down && ccm_light_load)
    begin
      s_d.ls_off    = 1'b1; // [RULE_07]
      s_d.pulse_cnt = 3'h0;
    end
    else if (s_q.ls_off && pwm_pulse)
    begin
      if (s_q.pulse_cnt == nb_rail_pkg::DVID_DOWN_PULSES - 3'h1)
        s_d.ls_off = 1'b0; // [RULE_07]
      else
        s_d.pulse_cnt = s_q.pulse_cnt + 3'h1;
    end

    s_d.ramp_sel = {diode_emulation, first_setting_pin[nb_rail_pkg::RAMP_LSB +: 2]}; // [RULE_08]

    if (adc_div > 22'(nb_rail_pkg::ADC_MAX_CODE))
      s_d.adc_code = nb_rail_pkg::ADC_MAX_CODE; // [RULE_09]
    else
      s_d.adc_code = adc_div[8:0];              // [RULE_09]
    // cheap average over about eight samples stands in for the sense filter
    s_d.acc       = s_q.acc - 12'(s_q.acc[11:3]) + 12'(s_q.adc_code);
    s_d.peak_over = current_monitor_pin >= nb_rail_pkg::ADC_FULL_UV; // [RULE_16]

    s_d.override = qr_pulse ? phase_mask(s_q.phases) : 2'b00; // [RULE_10]

    case (s_q.ocp)
      nb_rail_pkg::OCP_IDLE:
      begin
        if (enable && (sustained_overcurrent_trip || s_q.peak_over)) // [RULE_12]
        begin
          s_d.ocp    = nb_rail_pkg::OCP_TRIPPED; // [RULE_13]
          s_d.flag_n = 1'b0;                     // [RULE_13]
        end
      end
      nb_rail_pkg::OCP_TRIPPED:
      begin
        if (action_done)
        begin
          s_d.ocp       = nb_rail_pkg::OCP_SHUTDOWN;
          s_d.gates_off = 1'b1; // [RULE_14]
        end
      end
      nb_rail_pkg::OCP_SHUTDOWN:
        s_d.gates_off = 1'b1;
      default:
        s_d.ocp = nb_rail_pkg::OCP_IDLE;
    endcase
    if (enable && |per_phase_overcurrent)
      s_d.gates_off = 1'b1; // [RULE_17]
    // protection latches hold until the rail is disabled
    if (!enable)
    begin
      s_d.ocp       = nb_rail_pkg::OCP_IDLE;
      s_d.flag_n    = 1'b1;
      s_d.gates_off = 1'b0;
      s_d.ls_off    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_q        <= '0;
      s_q.phases <= nb_rail_pkg::PHASES_RST;
      s_q.ocp    <= nb_rail_pkg::OCP_IDLE;
      s_q.flag_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign rail_target_mv         = s_q.rail_target;
  assign phase_count            = s_q.phases;
  assign slew_compensation_bits = s_q.slew;
  assign vid_change_done        = s_q.vid_done;
  assign low_side_off           = s_q.ls_off;
  assign ramp_select            = s_q.ramp_sel;
  assign load_current_code      = s_q.adc_code;
  assign on_time_override       = s_q.override;
  assign peak_overcurrent_trip  = s_q.peak_over;
  assign overcurrent_flag_n     = s_q.flag_n;
  assign gates_off              = s_q.gates_off;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_init_off;
    enable && !s_q.en_prev && offset_input_pin < nb_rail_pkg::OFFSET_MIN_MV |=> !s_q.init_ofs_en;
  endproperty
  a_init_off: assert property (p_init_off) else $error("initial offset not disabled"); // [RULE_01]

  property p_dvid_up;
    dvid_up |=> phase_count == 2'h2;
  endproperty
  a_dvid_up: assert property (p_dvid_up) else $error("upward change did not force two phases"); // [RULE_04]

  property p_dvid_down;
    dvid_down && !dvid_up |=> $stable(phase_count);
  endproperty
  a_dvid_down: assert property (p_dvid_down) else $error("downward change altered phase count"); // [RULE_05]

  property p_ls_release;
    low_side_off && pwm_pulse && s_q.pulse_cnt == 3'h3 && !dvid_down |=> !low_side_off;
  endproperty
  a_ls_release: assert property (p_ls_release) else $error("low side not released after four pulses"); // [RULE_07]

  property p_ramp;
    diode_emulation |=> ramp_select[2] ##1 ramp_select[2] || !diode_emulation;
  endproperty
  a_ramp: assert property (p_ramp) else $error("diode emulation ramp not selected"); // [RULE_08]

  property p_adc_zero;
    current_monitor_pin < nb_rail_pkg::ADC_LSB_UV |=> load_current_code == 9'h000;
  endproperty
  a_adc_zero: assert property (p_adc_zero) else $error("sub-lsb monitor level not coded zero"); // [RULE_09]

  property p_peak_flag;
    enable && peak_overcurrent_trip && s_q.ocp == nb_rail_pkg::OCP_IDLE |=> !overcurrent_flag_n;
  endproperty
  a_peak_flag: assert property (p_peak_flag) else $error("peak trip did not raise flag"); // [RULE_12]

  property p_flag_hold;
    !overcurrent_flag_n && enable |=> !overcurrent_flag_n;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped while enabled"); // [RULE_13]

  property p_phase_ocp;
    enable && |per_phase_overcurrent ##1 enable |-> gates_off;
  endproperty
  a_phase_ocp: assert property (p_phase_ocp) else $error("per-phase overcurrent did not turn gates off"); // [RULE_17]

  property p_qr;
    qr_pulse && enable |=> on_time_override == phase_mask($past(phase_count));
  endproperty
  a_qr: assert property (p_qr) else $error("quick pulse not applied to active phases"); // [RULE_10]

endmodule // nb_rail_control

// ==== rtl/ocp_delay_timer.sv ====
`timescale 1ns/10ps
module ocp_delay_timer #(
  parameter int COUNT = 16
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // qualifying condition and expiry
  input  wire logic run,
  output logic      done
);

  nb_rail_pkg::timer_st_t s_q;
  nb_rail_pkg::timer_st_t s_d;

  // any gap in the condition starts the wait over from zero
  always_comb
  begin
    s_d = s_q;
    if (!run)
    begin
      s_d.cnt  = 16'h0000;
      s_d.done = 1'b0;
    end
    else if (s_q.cnt == 16'(COUNT - 1))
      s_d.done = 1'b1;
    else
      s_d.cnt = s_q.cnt + 16'h0001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done = s_q.done;

endmodule // ocp_delay_timer

// ==== rtl/quick_pulse_gen.sv ====
`timescale 1ns/10ps
module quick_pulse_gen (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // trigger and width
  input  wire logic       trigger,
  input  wire logic [7:0] on_cycles,
  output logic            pulse
);

  nb_rail_pkg::pulse_st_t s_q;
  nb_rail_pkg::pulse_st_t s_d;

  // a retrigger while busy is ignored so the width stays one on-time
  always_comb
  begin
    s_d = s_q;
    if (s_q.pulse)
    begin
      if (s_q.cnt <= 8'h01)
        s_d.pulse = 1'b0;
      else
        s_d.cnt = s_q.cnt - 8'h01;
    end
    else if (trigger && on_cycles != 8'h00)
    begin
      s_d.pulse = 1'b1;
      s_d.cnt   = on_cycles;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pulse = s_q.pulse;

endmodule // quick_pulse_gen

// ==== testbench/nb_rail_partner.sv ====
`timescale 1ns/10ps
module nb_rail_partner (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // power stage
  input  wire logic gates_off,
  output logic      pwm_pulse
);
  logic [1:0] div_q;

  // one pulse every third cycle; a stage that is shut down stops switching
  always_ff @(posedge clk_sys)
  begin
    div_q     <= (rst || div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    pwm_pulse <= !rst && !gates_off && div_q == 2'h2;
  end
endmodule // nb_rail_partner

// ==== testbench/tb_nb_rail_control.sv ====
`timescale 1ns/10ps
module tb_nb_rail_control;
  // short delays keep the run brief
  localparam int TRIG = 8;
  localparam int ACT  = 6;

  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               enable = 1'b0;
  logic [11:0]        vid_target_mv = 12'h000;
  logic signed [11:0] initial_offset_mv = 12'sh000;
  logic               dvid_up = 1'b0;
  logic               dvid_down = 1'b0;
  logic               dvid_settled = 1'b0;
  logic [1:0]         requested_phases = 2'h2;
  logic [11:0]        offset_input_pin = 12'h000;
  logic [2:0]         first_setting_pin = 3'h0;
  logic [2:0]         second_setting_pin = 3'h0;
  logic [21:0]        current_monitor_pin = 22'h000000;
  logic [1:0]         tdc_percent_sel = 2'h3;
  logic               ccm_light_load = 1'b0;
  logic               diode_emulation = 1'b0;
  logic               pwm_pulse;
  logic               qr_trigger = 1'b0;
  logic [7:0]         on_time_cycles = 8'h03;
  logic [1:0]         per_phase_overcurrent = 2'h0;
  logic signed [13:0] rail_target_mv;
  logic [1:0]         phase_count;
  logic [1:0]         slew_compensation_bits;
  logic               vid_change_done;
  logic               low_side_off;
  logic [2:0]         ramp_select;
  logic [8:0]         load_current_code;
  logic [1:0]         on_time_override;
  logic               sustained_overcurrent_trip;
  logic               peak_overcurrent_trip;
  logic               overcurrent_flag_n;
  logic               gates_off;
  int                 n_errors = 0;
  int                 n_checks = 0;

  always #10 clk_sys = ~clk_sys;

  nb_rail_control #(
    .TRIG_CYCLES   (TRIG),
    .ACTION_CYCLES (ACT)
  ) dut (
    .clk_sys                    (clk_sys),
    .rst                        (rst),
    .enable                     (enable),
    .vid_target_mv              (vid_target_mv),
    .initial_offset_mv          (initial_offset_mv),
    .dvid_up                    (dvid_up),
    .dvid_down                  (dvid_down),
    .dvid_settled               (dvid_settled),
    .requested_phases           (requested_phases),
    .offset_input_pin           (offset_input_pin),
    .first_setting_pin          (first_setting_pin),
    .second_setting_pin         (second_setting_pin),
    .current_monitor_pin        (current_monitor_pin),
    .tdc_percent_sel            (tdc_percent_sel),
    .ccm_light_load             (ccm_light_load),
    .diode_emulation            (diode_emulation),
    .pwm_pulse                  (pwm_pulse),
    .qr_trigger                 (qr_trigger),
    .on_time_cycles             (on_time_cycles),
    .per_phase_overcurrent      (per_phase_overcurrent),
    .rail_target_mv             (rail_target_mv),
    .phase_count                (phase_count),
    .slew_compensation_bits     (slew_compensation_bits),
    .vid_change_done            (vid_change_done),
    .low_side_off               (low_side_off),
    .ramp_select                (ramp_select),
    .load_current_code          (load_current_code),
    .on_time_override           (on_time_override),
    .sustained_overcurrent_trip (sustained_overcurrent_trip),
    .peak_overcurrent_trip      (peak_overcurrent_trip),
    .overcurrent_flag_n         (overcurrent_flag_n),
    .gates_off                  (gates_off)
  );
  nb_rail_partner partner (.clk_sys(clk_sys), .rst(rst), .gates_off(gates_off), .pwm_pulse(pwm_pulse));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic neg(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic int exp_target(input int vid, input int ofs, input int pin, input bit ext);
    int t;
    t = vid;
    if (pin >= 300)
      t += ofs;
    if (ext)
      t += pin - 1200;
    return t;
  endfunction

  function automatic logic [8:0] exp_code(input logic [21:0] uv);
    int c;
    c = int'(uv) / int'(nb_rail_pkg::ADC_LSB_UV);
    return (c > 511) ? 9'h1ff : 9'(c);
  endfunction

  initial
  begin
    #100000;
    n_errors++;
    end_of_test();
  end

  initial
  begin
    int pins[4] = '{100, 1300, 100, 300};
    int dly[4];
    int n;
    int p;
    dly = '{int'(nb_rail_pkg::COMP_DLY_0), int'(nb_rail_pkg::COMP_DLY_1),
            int'(nb_rail_pkg::COMP_DLY_2), int'(nb_rail_pkg::COMP_DLY_3)};
    void'($urandom(32'hbb52));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    neg(1);
    check({phase_count, overcurrent_flag_n, gates_off}, {2'h2, 1'b1, 1'b0});
    // offset pin is latched only at the enable edge, so cycle enable per case
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_sys);
      enable <= 1'b0;
      vid_target_mv <= 12'($urandom_range(400, 1500));
      initial_offset_mv <= 12'($signed($urandom_range(0, 127)) - 64);
      offset_input_pin <= 12'(pins[k]);
      second_setting_pin <= {2'h0, k == 1 || k == 2};
      @(posedge clk_sys);
      enable <= 1'b1;
      neg(3);
      check(32'(rail_target_mv), exp_target(vid_target_mv, initial_offset_mv, pins[k], k == 1 || k == 2));
    end
    // protection is ignored with the rail off, so the monitor may go past full scale here
    for (int i = 0; i < 24; i++)
    begin
      @(posedge clk_sys);
      enable <= 1'b0;
      first_setting_pin <= 3'($urandom);
      second_setting_pin <= 3'($urandom);
      diode_emulation <= 1'($urandom);
      current_monitor_pin <= (i == 0) ? 22'h000000 : (i == 1) ? nb_rail_pkg::ADC_FULL_UV :
                             (i == 2) ? nb_rail_pkg::ADC_LSB_UV - 22'h000001 : 22'($urandom_range(0, 3300000));
      neg(2);
      check(ramp_select, {diode_emulation, first_setting_pin[1:0]});
      check(slew_compensation_bits, {first_setting_pin[2], second_setting_pin[2]});
      check(load_current_code, exp_code(current_monitor_pin));
    end
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk_sys);
      current_monitor_pin <= 22'h000000;
      first_setting_pin <= {s[1], 2'h0};
      second_setting_pin <= {s[0], 2'h0};
      repeat (3) @(posedge clk_sys);
      dvid_settled <= 1'b1;
      @(posedge clk_sys);
      dvid_settled <= 1'b0;
      n = 0;
      repeat (20)
      begin
        neg(1);
        n++;
        if (vid_change_done === 1'b1)
          break;
      end
      check(n, 2 + dly[s]);
    end
    @(posedge clk_sys);
    enable <= 1'b1;
    requested_phases <= 2'h1;
    neg(3);
    check(phase_count, 2'h1);
    @(posedge clk_sys);
    dvid_up <= 1'b1;
    @(posedge clk_sys);
    dvid_up <= 1'b0;
    neg(1);
    check(phase_count, 2'h2);
    neg(3);
    p = phase_count;
    @(posedge clk_sys);
    dvid_down <= 1'b1;
    requested_phases <= 2'h0;
    @(posedge clk_sys);
    dvid_down <= 1'b0;
    neg(1);
    check(phase_count, p);
    @(posedge clk_sys);
    // start the down step just after a switching pulse so the count is unambiguous
    requested_phases <= 2'h2;
    ccm_light_load <= 1'b1;
    repeat (4)
    begin
      neg(1);
      if (pwm_pulse === 1'b1)
        break;
    end
    @(posedge clk_sys);
    dvid_down <= 1'b1;
    @(posedge clk_sys);
    dvid_down <= 1'b0;
    n = 0;
    repeat (30)
    begin
      neg(1);
      if (low_side_off !== 1'b1)
        break;
      n += int'(pwm_pulse);
    end
    check(n, 4);
    @(posedge clk_sys);
    ccm_light_load <= 1'b0;
    qr_trigger <= 1'b1;
    @(posedge clk_sys);
    qr_trigger <= 1'b0;
    n = 0;
    repeat (12)
    begin
      neg(1);
      n += int'(on_time_override === 2'h3);
    end
    check(n, 3);
    @(posedge clk_sys);
    current_monitor_pin <= 22'(3000000);
    neg(60);
    check({sustained_overcurrent_trip, overcurrent_flag_n}, 2'b01);
    @(posedge clk_sys);
    tdc_percent_sel <= 2'h0;
    neg(4);
    check(sustained_overcurrent_trip, 1'b0);
    neg(TRIG + 8);
    check({sustained_overcurrent_trip, peak_overcurrent_trip, overcurrent_flag_n}, 3'b100);
    @(posedge clk_sys);
    enable <= 1'b0;
    tdc_percent_sel <= 2'h3;
    current_monitor_pin <= 22'h000000;
    neg(30);
    check({overcurrent_flag_n, gates_off}, 2'b10);
    @(posedge clk_sys);
    enable <= 1'b1;
    @(posedge clk_sys);
    current_monitor_pin <= nb_rail_pkg::ADC_FULL_UV;
    neg(4);
    check({peak_overcurrent_trip, overcurrent_flag_n, gates_off}, 3'b100);
    neg(ACT + 4);
    check(gates_off, 1'b1);
    @(posedge clk_sys);
    enable <= 1'b0;
    current_monitor_pin <= 22'h000000;
    neg(30);
    @(posedge clk_sys);
    enable <= 1'b1;
    neg(3);
    check(gates_off, 1'b0);
    @(posedge clk_sys);
    per_phase_overcurrent <= 2'h1;
    neg(4);
    check(gates_off, 1'b1);
    end_of_test();
  end
endmodule // tb_nb_rail_control
